// >>> src/pnp_pkg.sv
package pnp_pkg;
  // ----------------------------------------------------------------
  // Action and command codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD = 2'b10;
  localparam logic [1:0] ACT_IDLE = 2'b11;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_PROT = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_ID = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] FUSE_RESET = 6'h1a;
  localparam logic [1:0] PROT_RESET = 2'b11;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;
  localparam int PROT_FIRST_POS = 1;
  localparam int PROT_SECOND_POS = 2;
  localparam int FUSE_W = 6;
  localparam int EEPROM_DEPTH = 256;
  localparam int ID_BYTES = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int ENTRY_SETUP_NS = 100;
  localparam int ENTRY_CYCLES = (ENTRY_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int BYTE_WRITE_MIN_NS = 500000;
  localparam int BYTE_WRITE_CYCLES =
    (BYTE_WRITE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_CNT_W = 20;
  localparam int ENTRY_CNT_W = 8;
  // ----------------------------------------------------------------
  // Entry states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PNP_OFF = 2'b00,
    PNP_ARMED = 2'b01,
    PNP_SETTLE = 2'b10,
    PNP_ACTIVE = 2'b11
  } pnp_entry_e;
endpackage : pnp_pkg

// >>> src/pnp_prog_port.sv
`timescale 1ns/1ps
module pnp_prog_port #(
  parameter int FLASH_ADDR_W = 11,
  parameter int WRITE_CYCLES = pnp_pkg::BYTE_WRITE_CYCLES,
  parameter logic [7:0] ID_BYTE0 = 8'h5a, // Arbitrary value
  parameter logic [7:0] ID_BYTE1 = 8'h3c, // Arbitrary value
  parameter logic [7:0] ID_BYTE2 = 8'h01  // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PROG_VOLTAGE,
  input wire logic CRYSTAL_STROBE_INPUT,
  input wire logic ACTION_SELECT_MSB,
  input wire logic ACTION_SELECT_LSB,
  input wire logic BYTE_SELECT,
  input wire logic WRITE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic READY_BUSY_OUT,
  output logic PROG_MODE_ACTIVE,
  output logic [pnp_pkg::FUSE_W-1:0] FUSE_BITS,
  output logic [1:0] PROTECT_BITS,
  input wire logic [1:0] SERIAL_ID_INDEX,
  output logic [7:0] SERIAL_ID_DATA
);
  import pnp_pkg::*;
  default clocking ast_cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  localparam int FLASH_WORDS = 2 ** FLASH_ADDR_W;

  if (FLASH_ADDR_W < 8 || FLASH_ADDR_W > 11)
    $error("FLASH_ADDR_W must lie in 8..11");
  if (WRITE_CYCLES < 2 || WRITE_CYCLES >= 2 ** BUSY_CNT_W)
    $error("WRITE_CYCLES out of counter range");

  // ----------------------------------------------------------------
  // Strobe edges and entry sequence
  // ----------------------------------------------------------------
  logic xtal_d_reg;
  logic wr_n_d_reg;
  logic bs_d_reg;
  pnp_entry_e entry_reg;
  pnp_entry_e entry_next;
  logic [ENTRY_CNT_W-1:0] entry_cnt_reg;
  logic [ENTRY_CNT_W-1:0] entry_cnt_next;
  logic active_reg;
  logic xtal_rise;
  logic wr_fall;
  logic [1:0] act;

  assign act = {ACTION_SELECT_MSB, ACTION_SELECT_LSB};
  assign xtal_rise = CRYSTAL_STROBE_INPUT && !xtal_d_reg;
  assign wr_fall = !WRITE_N && wr_n_d_reg;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      xtal_d_reg <= 1'b0;
      wr_n_d_reg <= 1'b1;
      bs_d_reg <= 1'b0;
    end else begin
      xtal_d_reg <= CRYSTAL_STROBE_INPUT;
      wr_n_d_reg <= WRITE_N;
      bs_d_reg <= BYTE_SELECT;
    end
  end

  always_comb begin
    entry_next = entry_reg;
    entry_cnt_next = '0;
    unique case (entry_reg)
      PNP_OFF: begin
        if (!PROG_VOLTAGE && !BYTE_SELECT) begin
          entry_cnt_next = entry_cnt_reg + 1'b1;
          if (entry_cnt_reg == ENTRY_CNT_W'(ENTRY_CYCLES - 1)) begin
            entry_next = PNP_ARMED;
          end
        end
      end
      PNP_ARMED: begin
        if (BYTE_SELECT) begin
          entry_next = PNP_OFF;
        end else if (PROG_VOLTAGE) begin
          entry_next = PNP_SETTLE;
        end
      end
      PNP_SETTLE: begin
        if (!PROG_VOLTAGE || BYTE_SELECT != bs_d_reg) begin
          entry_next = PNP_OFF;
        end else begin
          entry_cnt_next = entry_cnt_reg + 1'b1;
          if (entry_cnt_reg == ENTRY_CNT_W'(ENTRY_CYCLES - 1)) begin
            entry_next = PNP_ACTIVE;
          end
        end
      end
      PNP_ACTIVE: begin
        if (!PROG_VOLTAGE) begin
          entry_next = PNP_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      entry_reg <= PNP_OFF;
      entry_cnt_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      entry_reg <= entry_next;
      entry_cnt_reg <= entry_cnt_next;
      active_reg <= (entry_next == PNP_ACTIVE);
    end
  end

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_hi_reg;
  logic [7:0] data_lo_reg;
  logic [15:0] addr_wide;
  logic [FLASH_ADDR_W-1:0] flash_addr;

  assign addr_wide = {addr_hi_reg, addr_lo_reg};
  assign flash_addr = addr_wide[FLASH_ADDR_W-1:0];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      data_hi_reg <= 8'h00;
      data_lo_reg <= 8'h00;
    end else if (xtal_rise && active_reg) begin
      unique case (act)
        ACT_ADDR: begin
          if (BYTE_SELECT) begin
            addr_hi_reg <= DATA_IN;
          end else begin
            addr_lo_reg <= DATA_IN;
          end
        end
        ACT_DATA: begin
          if (BYTE_SELECT) begin
            data_hi_reg <= DATA_IN;
          end else begin
            data_lo_reg <= DATA_IN;
          end
        end
        ACT_CMD: begin
          cmd_reg <= DATA_IN;
        end
        ACT_IDLE: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write strobe decode, protection and fuses
  // ----------------------------------------------------------------
  logic [FUSE_W-1:0] fuse_reg;
  logic [1:0] prot_reg;
  logic ready_reg;
  logic erasing_reg;
  logic [FLASH_ADDR_W-1:0] erase_addr_reg;
  logic erase_last;
  logic prog_blocked;
  logic mode3;
  logic wr_take;
  logic byte_start;

  assign prog_blocked = !prot_reg[0];
  assign mode3 = (prot_reg == 2'b00);
  assign wr_take = wr_fall && active_reg && ready_reg && !erasing_reg;
  assign byte_start = wr_take && !prog_blocked &&
    (cmd_reg == CMD_WR_FLASH || cmd_reg == CMD_WR_EEPROM);
  assign erase_last = (erase_addr_reg == FLASH_ADDR_W'(FLASH_WORDS - 1));

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fuse_reg <= FUSE_RESET;
    end else if (wr_take && cmd_reg == CMD_WR_FUSE && !prog_blocked) begin
      fuse_reg <= data_lo_reg[FUSE_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prot_reg <= PROT_RESET;
    end else if (erasing_reg && erase_last) begin
      prot_reg <= PROT_RESET;
    end else if (wr_take && cmd_reg == CMD_WR_PROT) begin
      prot_reg <= prot_reg & {data_lo_reg[PROT_SECOND_POS],
                              data_lo_reg[PROT_FIRST_POS]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      erasing_reg <= 1'b0;
      erase_addr_reg <= '0;
    end else if (erasing_reg) begin
      erase_addr_reg <= erase_addr_reg + 1'b1;
      if (erase_last) begin
        erasing_reg <= 1'b0;
      end
    end else if (wr_take && cmd_reg == CMD_ERASE) begin
      erasing_reg <= 1'b1;
      erase_addr_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Byte programming timer
  // ----------------------------------------------------------------
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [1:0] tgt_sel_reg;
  logic [FLASH_ADDR_W-1:0] tgt_addr_reg;
  logic [7:0] tgt_data_reg;
  logic busy_done;

  assign busy_done = !ready_reg &&
    busy_cnt_reg == BUSY_CNT_W'(WRITE_CYCLES - 1);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ready_reg <= 1'b1;
      busy_cnt_reg <= '0;
      tgt_sel_reg <= 2'b00;
      tgt_addr_reg <= '0;
      tgt_data_reg <= 8'h00;
    end else if (byte_start) begin
      ready_reg <= 1'b0;
      busy_cnt_reg <= '0;
      tgt_data_reg <= (BYTE_SELECT && cmd_reg == CMD_WR_FLASH) ?
        data_hi_reg : data_lo_reg;
      tgt_addr_reg <= (cmd_reg == CMD_WR_FLASH) ? flash_addr :
        FLASH_ADDR_W'(addr_lo_reg);
      tgt_sel_reg <= (cmd_reg == CMD_WR_EEPROM) ? 2'b10 :
        {1'b0, BYTE_SELECT};
    end else if (busy_done) begin
      ready_reg <= 1'b1;
    end else if (!ready_reg) begin
      busy_cnt_reg <= busy_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arrays
  // ----------------------------------------------------------------
  logic [7:0] flash_lo_mem [FLASH_WORDS] = '{default: ERASED_BYTE};
  logic [7:0] flash_hi_mem [FLASH_WORDS] = '{default: ERASED_BYTE};
  logic [7:0] eeprom_mem [EEPROM_DEPTH] = '{default: ERASED_BYTE};

  always_ff @(posedge CLK) begin
    if (erasing_reg) begin
      flash_lo_mem[erase_addr_reg] <= ERASED_BYTE;
      flash_hi_mem[erase_addr_reg] <= ERASED_BYTE;
      eeprom_mem[erase_addr_reg[7:0]] <= ERASED_BYTE;
    end else if (busy_done) begin
      unique case (tgt_sel_reg)
        2'b00: flash_lo_mem[tgt_addr_reg] <= tgt_data_reg;
        2'b01: flash_hi_mem[tgt_addr_reg] <= tgt_data_reg;
        2'b10: eeprom_mem[tgt_addr_reg[7:0]] <= tgt_data_reg;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  function automatic logic [7:0] id_byte(input logic [7:0] idx);
    unique case (idx)
      8'h00: id_byte = ID_BYTE0;
      8'h01: id_byte = ID_BYTE1;
      8'h02: id_byte = ID_BYTE2;
      default: id_byte = BLOCKED_BYTE;
    endcase
  endfunction : id_byte

  logic [7:0] rd_data;
  logic [7:0] data_out_reg;
  logic data_oe_reg;
  logic [7:0] serial_id_reg;

  always_comb begin
    rd_data = ERASED_BYTE;
    unique case (cmd_reg)
      CMD_RD_ID: rd_data = id_byte(addr_lo_reg);
      CMD_RD_FUSE: rd_data = BYTE_SELECT ?
        {5'h1f, prot_reg, 1'b1} : {2'b11, fuse_reg};
      CMD_RD_FLASH: rd_data = mode3 ? BLOCKED_BYTE :
        (BYTE_SELECT ? flash_hi_mem[flash_addr] : flash_lo_mem[flash_addr]);
      CMD_RD_EEPROM: rd_data = mode3 ? BLOCKED_BYTE :
        eeprom_mem[addr_lo_reg];
      default: rd_data = ERASED_BYTE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_out_reg <= 8'h00;
      data_oe_reg <= 1'b0;
      serial_id_reg <= 8'h00;
    end else begin
      data_out_reg <= rd_data;
      data_oe_reg <= active_reg && !OUTPUT_ENABLE_N;
      serial_id_reg <= mode3 ? {6'h00, SERIAL_ID_INDEX} :
        id_byte({6'h00, SERIAL_ID_INDEX});
    end
  end

  assign DATA_OUT = data_out_reg;
  assign DATA_OE = data_oe_reg;
  assign READY_BUSY_OUT = ready_reg;
  assign PROG_MODE_ACTIVE = active_reg;
  assign FUSE_BITS = fuse_reg;
  assign PROTECT_BITS = prot_reg;
  assign SERIAL_ID_DATA = serial_id_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CMD_LOAD: assert property (
    xtal_rise && active_reg && act == ACT_CMD |=>
      cmd_reg == $past(DATA_IN)) else $error("Command byte not loaded");
  AST_IDLE_KEEP: assert property (
    xtal_rise && act == ACT_IDLE |=> $stable(cmd_reg) &&
      $stable(addr_wide) && $stable({data_hi_reg, data_lo_reg}))
    else $error("Idle action changed a holding register");
  AST_BUSY_START: assert property (
    byte_start |=> !READY_BUSY_OUT[*2])
    else $error("Ready/busy did not fall on byte write");
  AST_BUSY_LEN: assert property (
    $rose(READY_BUSY_OUT) |->
      $past(busy_cnt_reg) == BUSY_CNT_W'(WRITE_CYCLES - 1))
    else $error("Byte write time wrong");
  AST_ERASE_QUIET: assert property (
    erasing_reg |-> READY_BUSY_OUT)
    else $error("Ready/busy moved during erase");
  AST_PROT_RELEASE: assert property (
    $changed(PROTECT_BITS) && PROTECT_BITS == PROT_RESET |->
      $past(erasing_reg) && $past(erase_last))
    else $error("Protection released before erase end");
  AST_LOCK_BLOCK: assert property (
    wr_take && prog_blocked |=> READY_BUSY_OUT && $stable(FUSE_BITS))
    else $error("Protected write was taken");
  AST_VERIFY_BLOCK: assert property (
    mode3 && cmd_reg == CMD_RD_FLASH |=> DATA_OUT == BLOCKED_BYTE)
    else $error("Verify read not blocked");
  AST_OE_DRIVE: assert property (
    DATA_OE |-> $past(!OUTPUT_ENABLE_N) && $past(PROG_MODE_ACTIVE))
    else $error("Data bus driven without output enable");
  AST_SERIAL_ID: assert property (
    mode3 ##1 mode3 |-> SERIAL_ID_DATA == {6'h00, $past(SERIAL_ID_INDEX)})
    else $error("Serial identification not masked");
endmodule : pnp_prog_port

// >>> dv/pnp_programmer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External parallel programmer model
// ----------------------------------------------------------------
module pnp_programmer (
  input wire logic clk,
  input wire logic ready_busy,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic prog_voltage,
  output logic crystal,
  output logic act_msb,
  output logic act_lsb,
  output logic byte_sel,
  output logic write_n,
  output logic oe_n,
  output logic [7:0] data
);
  initial begin
    {prog_voltage, crystal, act_msb, act_lsb} = 4'h3;
    {byte_sel, write_n, oe_n, data} = {3'h3, 8'h00};
  end

  // Entry; glitch toggles byte select while the voltage settles
  task automatic enter(input logic glitch);
    {prog_voltage, byte_sel} = 2'h0;
    repeat (30) @(negedge clk);
    prog_voltage = 1'b1;
    repeat (5) @(negedge clk);
    byte_sel = glitch;
    repeat (40) @(negedge clk);
    byte_sel = 1'b0;
  endtask : enter

  // One crystal pulse with the action pair, byte select and data
  task automatic load(input logic [1:0] act, input logic bs,
                      input logic [7:0] val);
    {act_msb, act_lsb, byte_sel, data, crystal} = {act, bs, val, 1'b1};
    @(negedge clk);
    crystal = 1'b0;
    @(negedge clk);
  endtask : load

  // Write pulse of a given width; counts cycles seen busy in a window
  task automatic write_strobe(input logic bs, input int width,
                              input int window, output int busy);
    busy = 0;
    byte_sel = bs;
    @(negedge clk);
    write_n = 1'b0;
    for (int i = 0; i < window; i++) begin
      @(negedge clk);
      if (i == width - 1) write_n = 1'b1;
      if (ready_busy !== 1'b1) busy++;
    end
  endtask : write_strobe

  // Bus released and inverted while the device drives it
  task automatic read(input logic bs, output logic [7:0] val,
                      output logic oe);
    {byte_sel, oe_n} = {bs, 1'b0};
    data = ~data;
    repeat (2) @(negedge clk);
    {val, oe} = {data_out, data_oe};
    oe_n = 1'b1;
    @(negedge clk);
  endtask : read
endmodule : pnp_programmer

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Programming port testbench
// ----------------------------------------------------------------
module testbench;
  import pnp_pkg::*;
  localparam int WCYC = 20;
  localparam logic [7:0] ID0 = 8'h6b; // Arbitrary value
  localparam logic [7:0] ID1 = 8'h2d; // Arbitrary value
  localparam logic [7:0] ID2 = 8'h47; // Arbitrary value
  logic clk, reset_n, prog_voltage, crystal, act_msb, act_lsb, byte_sel;
  logic write_n, oe_n, data_oe, ready, prog_active;
  logic [7:0] prog_data, data_out, data_bus, serial_data;
  logic [5:0] fuse_bits;
  logic [1:0] protect_bits, serial_index;
  int bad_count, total_checks;

  assign data_bus = data_oe ? data_out : prog_data;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  pnp_prog_port #(.FLASH_ADDR_W(11), .WRITE_CYCLES(WCYC),
    .ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2)) pnp_prog_port_i (
    .CLK(clk), .RESET_N(reset_n), .PROG_VOLTAGE(prog_voltage),
    .CRYSTAL_STROBE_INPUT(crystal), .ACTION_SELECT_MSB(act_msb),
    .ACTION_SELECT_LSB(act_lsb), .BYTE_SELECT(byte_sel),
    .WRITE_N(write_n), .OUTPUT_ENABLE_N(oe_n), .DATA_IN(data_bus),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .READY_BUSY_OUT(ready),
    .PROG_MODE_ACTIVE(prog_active), .FUSE_BITS(fuse_bits),
    .PROTECT_BITS(protect_bits), .SERIAL_ID_INDEX(serial_index),
    .SERIAL_ID_DATA(serial_data));

  pnp_programmer pnp_programmer_i (
    .clk(clk), .ready_busy(ready), .data_out(data_out),
    .data_oe(data_oe), .prog_voltage(prog_voltage), .crystal(crystal),
    .act_msb(act_msb), .act_lsb(act_lsb), .byte_sel(byte_sel),
    .write_n(write_n), .oe_n(oe_n), .data(prog_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic setup(input logic [7:0] cmd, input logic [7:0] hi,
                       input logic [7:0] lo);
    pnp_programmer_i.load(ACT_CMD, 1'b0, cmd);
    pnp_programmer_i.load(ACT_ADDR, 1'b1, hi);
    pnp_programmer_i.load(ACT_ADDR, 1'b0, lo);
  endtask : setup

  task automatic rd(input logic bs, input logic [7:0] want);
    logic [7:0] val;
    logic oe;
    pnp_programmer_i.read(bs, val, oe);
    check(val, want);
    check(oe, 1'b1);
    check(data_oe, 1'b0);
  endtask : rd

  task automatic wr(input logic bs, input int width, input int window,
                    input int busy_want);
    int busy;
    pnp_programmer_i.write_strobe(bs, width, window, busy);
    check(busy, busy_want);
  endtask : wr

  task automatic cmd(input logic [7:0] code, input logic [7:0] dat);
    pnp_programmer_i.load(ACT_CMD, 1'b0, code);
    pnp_programmer_i.load(ACT_DATA, 1'b0, dat);
  endtask : cmd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(fuse_bits, 6'h1a);
    check(protect_bits, 2'h3);
    check({ready, data_oe, prog_active}, 3'h4);
    pnp_programmer_i.enter(1'b1);
    check(prog_active, 1'b0);
    pnp_programmer_i.enter(1'b0);
    check(prog_active, 1'b1);
    $display("test reset and entry done");
  endtask : t_reset

  task automatic t_ident();
    setup(CMD_RD_ID, 8'h00, 8'h00);
    rd(1'b0, ID0);
    pnp_programmer_i.load(ACT_ADDR, 1'b0, 8'h02);
    pnp_programmer_i.load(ACT_IDLE, 1'b0, 8'h01);
    rd(1'b0, ID2);
    pnp_programmer_i.load(ACT_ADDR, 1'b0, 8'h01);
    rd(1'b0, ID1);
    serial_index = 2'h1;
    repeat (2) @(negedge clk);
    check(serial_data, ID1);
    $display("test identification done");
  endtask : t_ident

  task automatic t_flash();
    setup(CMD_RD_FLASH, 8'h03, 8'h45);
    rd(1'b0, ERASED_BYTE);
    setup(CMD_WR_FLASH, 8'h03, 8'h45);
    pnp_programmer_i.load(ACT_DATA, 1'b0, 8'ha5);
    pnp_programmer_i.load(ACT_DATA, 1'b1, 8'h5c);
    wr(1'b0, 1, 3 * WCYC, WCYC);
    wr(1'b1, 1, 3 * WCYC, WCYC);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(1'b0, 8'ha5);
    rd(1'b1, 8'h5c);
    pnp_programmer_i.load(ACT_ADDR, 1'b1, 8'h00);
    rd(1'b0, ERASED_BYTE);
    setup(CMD_WR_EEPROM, 8'h00, 8'h7e);
    pnp_programmer_i.load(ACT_DATA, 1'b0, 8'h3d);
    wr(1'b0, 1, 3 * WCYC, WCYC);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
    rd(1'b0, 8'h3d);
    $display("test flash and eeprom done");
  endtask : t_flash

  task automatic t_protect();
    cmd(CMD_WR_FUSE, 8'hd5);
    wr(1'b0, 4, 8, 0);
    check(fuse_bits, 6'h15);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd(1'b0, 8'hd5);
    cmd(CMD_WR_PROT, 8'hfd);
    wr(1'b0, 1, 8, 0);
    check(protect_bits, 2'h2);
    setup(CMD_WR_FLASH, 8'h03, 8'h45);
    pnp_programmer_i.load(ACT_DATA, 1'b0, 8'h00);
    wr(1'b0, 1, 3 * WCYC, 0);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(1'b0, 8'ha5);
    cmd(CMD_WR_FUSE, 8'hc0);
    wr(1'b0, 4, 8, 0);
    check(fuse_bits, 6'h15);
    cmd(CMD_WR_PROT, 8'hfb);
    wr(1'b0, 1, 8, 0);
    check(protect_bits, 2'h0);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd(1'b1, 8'hf9);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(1'b0, BLOCKED_BYTE);
    serial_index = 2'h2;
    repeat (2) @(negedge clk);
    check(serial_data, 8'h02);
    $display("test protection done");
  endtask : t_protect

  task automatic t_erase();
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_ERASE);
    wr(1'b0, 2100, 2150, 0);
    check(protect_bits, 2'h3);
    check(fuse_bits, 6'h15);
    setup(CMD_RD_FLASH, 8'h03, 8'h45);
    rd(1'b0, ERASED_BYTE);
    setup(CMD_RD_EEPROM, 8'h00, 8'h7e);
    rd(1'b0, ERASED_BYTE);
    setup(CMD_WR_FLASH, 8'h03, 8'h45);
    pnp_programmer_i.load(ACT_DATA, 1'b0, 8'h3c);
    wr(1'b0, 1, 3 * WCYC, WCYC);
    pnp_programmer_i.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(1'b0, 8'h3c);
    $display("test chip erase done");
  endtask : t_erase

  initial begin
    {reset_n, serial_index} = 3'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_ident();
    t_flash();
    t_protect();
    t_erase();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Watchdog expired at %0t", $time);
    complete_run();
  end
endmodule : testbench
